// ===== src/mst_engine.sv
// Transfer engine that services routed interrupt requests by moving data
// between memory and peripheral registers, with AXI4-Lite control registers.
// Assumes one shared access port for memory and registers that answers with ack.
//
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module mst_engine #(
  parameter int unsigned AW = 8,
  parameter int unsigned XFER_W = 32
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite slave
  input wire logic [AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Service requests
  input wire logic req_valid,
  input wire mst_pkg::mst_req_t req,
  output logic req_ready,
  // Memory and register access
  output logic acc_req,
  output mst_pkg::mst_acc_t acc,
  input wire logic [23:0] acc_rdata,
  input wire logic acc_ack,
  // End of service
  output logic done_valid,
  output mst_pkg::mst_done_t done,
  output logic end_irq,
  input wire logic end_irq_ack
);
  typedef enum logic [4:0] {
    S_IDLE, S_CNT, S_PERIPH_REG_PTR, S_MP, S_XRD, S_XWR, S_TRD, S_CRD, S_CWR, S_PWB,
    S_DATA_DEST_PTR, S_MPD, S_ORD, S_OWR, S_RNG, S_RWB, S_DWB, S_CWB, S_DONE
  } mst_state_t;

  mst_state_t st_q, st_d;
  logic [7:0] mode_q, chp_q, periph_reg_ptr_q, data_dest_ptr_q, rc_q;
  logic [15:0] cnt_q, data_q;
  logic [23:0] ptr_q, mpd_q, ptr_next;
  logic pend_q, ack_go;
  mst_pkg::mst_acc_t acc_q, acc_d;
  mst_pkg::mst_done_t done_q;
  logic end_q, bad_q;
  logic [1:0] ctrl_q;
  logic [XFER_W-1:0] xfers_q;
  logic bvalid_q, rvalid_q, wr_go, rd_go;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [1:0] ctype;
  logic dir, wide, tstep, add, ring, suppress, cnt_zero;
  logic [11:0] base;
  logic [7:0] bufa, cnt_off;
  logic [19:0] bufaddr;

  // ==========================================================
  // Helpers
  function automatic logic [23:0] step_ptr(input logic [23:0] p, input logic dec,
                                           input logic [23:0] amt);
    step_ptr = dec ? p - amt : p + amt;
  endfunction

  function automatic logic [1:0] reg_index(input logic [AW-1:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    if (w == mst_pkg::REG_CTRL) reg_index = 2'h0;
    else if (w == mst_pkg::REG_STATUS) reg_index = 2'h1;
    else if (w == mst_pkg::REG_XFERS) reg_index = 2'h2;
    else reg_index = 2'h3;
  endfunction

  // ==========================================================
  // Mode decode
  assign ctype = mode_q[mst_pkg::MODE_TYPE_MSB:mst_pkg::MODE_TYPE_LSB];
  assign dir = mode_q[mst_pkg::MODE_DIR_BIT];
  assign wide = mode_q[mst_pkg::MODE_WIDE_BIT];
  assign tstep = mode_q[mst_pkg::MODE_TSTEP_BIT];
  assign add = mode_q[mst_pkg::MODE_ADD_BIT];
  assign ring = mode_q[mst_pkg::MODE_RING_BIT];
  assign suppress = mode_q[mst_pkg::MODE_SUPPRESS_BIT];
  // Channel lives in the RAM window, only its low byte is programmable
  assign base = ctrl_q[mst_pkg::CTRL_LOC_BIT] ? mst_pkg::RAM_BASE_HIGH
                                              : mst_pkg::RAM_BASE_LOW;
  assign cnt_zero = (ctype == mst_pkg::TYPE_A) ? (cnt_q[7:0] == 8'h00) : (cnt_q == 16'h0000);
  // Buffer index wraps inside the 256-byte window
  assign bufa = wide ? chp_q - {cnt_q[6:0], 1'b0} - mst_pkg::ONE8
                     : chp_q - cnt_q[7:0] - mst_pkg::ONE8;
  // Pointer bits 20 to 23 never reach the address bus
  assign bufaddr = (ctype == mst_pkg::TYPE_A) ? {base, bufa} : ptr_q[19:0];
  assign cnt_off = (ctype == mst_pkg::TYPE_A) ? chp_q : chp_q - mst_pkg::OFF_CNT_W;
  always_comb
  begin
    if (ctype == mst_pkg::TYPE_B)
      ptr_next = ptr_q + (wide ? mst_pkg::TWO24 : mst_pkg::ONE24);
    else
      ptr_next = step_ptr(ptr_q, dir, wide ? mst_pkg::TWO24 : mst_pkg::ONE24);
  end

  // ==========================================================
  // Access descriptor for the current step
  always_comb
  begin
    acc_d = '0;
    acc_d.size = wide ? mst_pkg::SIZE_2 : mst_pkg::SIZE_1;
    unique case (st_q)
      S_CNT:
      begin
        acc_d.addr = {base, cnt_off};
        acc_d.size = (ctype == mst_pkg::TYPE_A) ? mst_pkg::SIZE_1 : mst_pkg::SIZE_2;
      end
      S_PERIPH_REG_PTR:
      begin
        acc_d.size = mst_pkg::SIZE_1;
        acc_d.addr = {base, chp_q - ((ctype == mst_pkg::TYPE_A) ? mst_pkg::OFF_PERIPH_REG_PTR_A
                                                               : mst_pkg::OFF_PERIPH_REG_PTR_W)};
      end
      S_MP, S_PWB:
      begin
        acc_d.size = mst_pkg::SIZE_3;
        acc_d.addr = {base, chp_q - mst_pkg::OFF_MP};
        acc_d.we = (st_q == S_PWB);
        acc_d.wdata = ptr_next;
      end
      S_XRD:
      begin
        acc_d.peripheral_register = dir;
        acc_d.addr = dir ? {mst_pkg::SFR_BASE, periph_reg_ptr_q} : bufaddr;
      end
      S_XWR:
      begin
        acc_d.peripheral_register = !dir;
        acc_d.we = 1'b1;
        acc_d.addr = dir ? bufaddr : {mst_pkg::SFR_BASE, periph_reg_ptr_q};
        acc_d.wdata = {8'h00, data_q};
      end
      S_TRD: acc_d.addr = ptr_q[19:0];
      S_CRD, S_CWR:
      begin
        acc_d.peripheral_register = 1'b1;
        acc_d.we = (st_q == S_CWR);
        acc_d.addr = {mst_pkg::SFR_BASE, periph_reg_ptr_q};
        acc_d.wdata = {8'h00, data_q};
      end
      S_DATA_DEST_PTR:
      begin
        acc_d.size = mst_pkg::SIZE_1;
        acc_d.addr = {base, chp_q - mst_pkg::OFF_DATA_DEST_PTR};
      end
      S_MPD, S_DWB:
      begin
        acc_d.size = mst_pkg::SIZE_3;
        acc_d.addr = {base, chp_q - mst_pkg::OFF_MPD};
        acc_d.we = (st_q == S_DWB);
        acc_d.wdata = mpd_q;
      end
      S_ORD:
      begin
        acc_d.size = mst_pkg::SIZE_1;
        acc_d.addr = mpd_q[19:0];
      end
      S_OWR:
      begin
        acc_d.peripheral_register = 1'b1;
        acc_d.we = 1'b1;
        acc_d.size = mst_pkg::SIZE_1;
        acc_d.addr = {mst_pkg::SFR_BASE, data_dest_ptr_q};
        acc_d.wdata = {8'h00, data_q};
      end
      S_RNG, S_RWB:
      begin
        acc_d.size = (st_q == S_RNG) ? mst_pkg::SIZE_2 : mst_pkg::SIZE_1;
        acc_d.addr = {base, chp_q - mst_pkg::OFF_RING};
        acc_d.we = (st_q == S_RWB);
        acc_d.wdata = {16'h0000, rc_q};
      end
      S_CWB:
      begin
        acc_d.addr = {base, cnt_off};
        acc_d.size = (ctype == mst_pkg::TYPE_A) ? mst_pkg::SIZE_1 : mst_pkg::SIZE_2;
        acc_d.we = 1'b1;
        acc_d.wdata = {8'h00, cnt_q - 16'h0001};
      end
      default: acc_d.addr = '0;
    endcase
  end

  // ==========================================================
  // Step sequencing after each acknowledged access
  always_comb
  begin
    unique case (st_q)
      S_CNT: st_d = S_PERIPH_REG_PTR;
      S_PERIPH_REG_PTR: st_d = (ctype == mst_pkg::TYPE_A) ? S_XRD : S_MP;
      S_MP: st_d = (ctype == mst_pkg::TYPE_C) ? S_TRD : S_XRD;
      S_XRD: st_d = S_XWR;
      S_XWR: st_d = (ctype == mst_pkg::TYPE_B) ? S_PWB : S_CWB;
      S_TRD: st_d = add ? S_CRD : S_CWR;
      S_CRD: st_d = S_CWR;
      S_CWR: st_d = tstep ? S_PWB : S_DATA_DEST_PTR;
      S_PWB: st_d = (ctype == mst_pkg::TYPE_C) ? S_DATA_DEST_PTR : S_CWB;
      S_DATA_DEST_PTR: st_d = S_MPD;
      S_MPD: st_d = S_ORD;
      S_ORD: st_d = S_OWR;
      S_OWR: st_d = ring ? S_RNG : S_DWB;
      S_RNG: st_d = S_RWB;
      S_RWB: st_d = S_DWB;
      S_DWB: st_d = S_CWB;
      S_CWB: st_d = S_DONE;
      default: st_d = S_IDLE;
    endcase
  end

  assign ack_go = ce && pend_q && acc_ack;
  assign req_ready = ce && (st_q == S_IDLE) && ctrl_q[mst_pkg::CTRL_EN_BIT];
  assign acc_req = pend_q;
  assign acc = acc_q;
  assign done_valid = (st_q == S_DONE);
  assign done = done_q;
  assign end_irq = end_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= S_IDLE;
      pend_q <= 1'b0;
      acc_q <= '0;
    end
    else if (ce)
    begin
      unique case (st_q)
        S_IDLE:
          if (req_valid && req_ready)
            st_q <= (req.mode[mst_pkg::MODE_TYPE_MSB:mst_pkg::MODE_TYPE_LSB]
                     == mst_pkg::TYPE_CNT) ? S_DONE : S_CNT;
        S_DONE: st_q <= S_IDLE;
        default:
          if (!pend_q)
          begin
            pend_q <= 1'b1;
            acc_q <= acc_d;
          end
          else if (acc_ack)
          begin
            pend_q <= 1'b0;
            st_q <= st_d;
          end
      endcase
    end
  end

  // ==========================================================
  // Channel data captured from answers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_q <= '0;
      chp_q <= '0;
      cnt_q <= '0;
      periph_reg_ptr_q <= '0;
      ptr_q <= '0;
      data_dest_ptr_q <= '0;
      mpd_q <= '0;
      data_q <= '0;
      rc_q <= '0;
      done_q <= '0;
    end
    else if (ce)
    begin
      if (st_q == S_IDLE && req_valid && req_ready)
      begin
        mode_q <= req.mode;
        chp_q <= req.chan_ptr;
        done_q <= '0;
      end
      if (ack_go)
      begin
        unique case (st_q)
          S_CNT: cnt_q <= (ctype == mst_pkg::TYPE_A) ? {8'h00, acc_rdata[7:0]} : acc_rdata[15:0];
          S_PERIPH_REG_PTR: periph_reg_ptr_q <= acc_rdata[7:0];
          S_MP: ptr_q <= acc_rdata;
          S_XRD, S_TRD: data_q <= wide ? acc_rdata[15:0] : {8'h00, acc_rdata[7:0]};
          S_CRD: data_q <= wide ? data_q + acc_rdata[15:0]
                                : {8'h00, data_q[7:0] + acc_rdata[7:0]};
          S_DATA_DEST_PTR: data_dest_ptr_q <= acc_rdata[7:0];
          S_MPD: mpd_q <= acc_rdata;
          S_ORD: data_q <= {8'h00, acc_rdata[7:0]};
          S_OWR: mpd_q <= step_ptr(mpd_q, dir, mst_pkg::ONE24);
          S_RNG:
          begin
            if (acc_rdata[7:0] == mst_pkg::ONE8)
            begin
              rc_q <= acc_rdata[15:8];
              mpd_q <= step_ptr(mpd_q, !dir, {16'h0000, acc_rdata[15:8]});
            end
            else
              rc_q <= acc_rdata[7:0] - mst_pkg::ONE8;
          end
          S_CWB:
          begin
            cnt_q <= cnt_q - 16'h0001;
            done_q.clr_ism <= (acc_q.wdata[15:0] == 16'h0000)
                              || (ctype == mst_pkg::TYPE_A && acc_q.wdata[7:0] == 8'h00);
            done_q.clr_flag <= suppress && ((acc_q.wdata[15:0] == 16'h0000)
                              || (ctype == mst_pkg::TYPE_A && acc_q.wdata[7:0] == 8'h00));
          end
          default: data_q <= data_q;
        endcase
      end
    end
  end

  // ==========================================================
  // End-of-service interrupt, held until the controller takes it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      end_q <= 1'b0;
    else if (ce)
    begin
      if (done_valid && done_q.clr_ism && !suppress)
        end_q <= 1'b1;
      else if (end_irq_ack)
        end_q <= 1'b0;
    end
  end

  // Sticky flag for requests in a mode this engine does not serve
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      bad_q <= 1'b0;
    else if (ce)
    begin
      if (st_q == S_IDLE && req_valid && req_ready
          && req.mode[mst_pkg::MODE_TYPE_MSB:mst_pkg::MODE_TYPE_LSB] == mst_pkg::TYPE_CNT)
        bad_q <= 1'b1;
      else if (wr_go && reg_index(awaddr) == 2'h1 && wstrb[0] && wdata[mst_pkg::ST_BAD_BIT])
        bad_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      xfers_q <= '0;
    else if (ack_go && st_q == S_CWB)
      xfers_q <= xfers_q + {{(XFER_W-1){1'b0}}, 1'b1};
  end

  // ==========================================================
  // AXI4-Lite slave
  assign wr_go = ce && awvalid && wvalid && !bvalid_q;
  assign rd_go = ce && arvalid && !rvalid_q;
  assign awready = wr_go;
  assign wready = wr_go;
  assign arready = rd_go;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= mst_pkg::CTRL_RESET;
      bvalid_q <= 1'b0;
      bresp_q <= mst_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (wr_go)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= (reg_index(awaddr) == 2'h3) ? mst_pkg::RESP_SLVERR : mst_pkg::RESP_OKAY;
        if (reg_index(awaddr) == 2'h0 && wstrb[0])
          ctrl_q <= wdata[1:0];
      end
      else if (bready)
        bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= mst_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (rd_go)
      begin
        rvalid_q <= 1'b1;
        rresp_q <= mst_pkg::RESP_OKAY;
        unique case (reg_index(araddr))
          2'h0: rdata_q <= {30'h0, ctrl_q};
          2'h1: rdata_q <= {29'h0, bad_q, end_q, st_q != S_IDLE};
          2'h2: rdata_q <= 32'(xfers_q);
          default:
          begin
            rdata_q <= '0;
            rresp_q <= mst_pkg::RESP_SLVERR;
          end
        endcase
      end
      else if (rready)
        rvalid_q <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  req_take_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (req_valid && req_ready && req.mode[1:0] != mst_pkg::TYPE_CNT)
      |=> (st_q == S_CNT) && (chp_q == $past(req.chan_ptr)))
    else $error("accepted request did not start channel read");
  bufa_byte_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (pend_q && ctype == mst_pkg::TYPE_A && !wide && !acc_q.peripheral_register && (st_q == S_XRD || st_q == S_XWR))
      |-> acc_q.addr == {base, chp_q - cnt_q[7:0] - mst_pkg::ONE8})
    else $error("type A byte buffer address wrong");
  bufa_word_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (pend_q && ctype == mst_pkg::TYPE_A && wide && !acc_q.peripheral_register && (st_q == S_XRD || st_q == S_XWR))
      |-> acc_q.addr[7:0] == chp_q - {cnt_q[6:0], 1'b0} - mst_pkg::ONE8)
    else $error("type A word buffer address wrong");
  typeb_addr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (pend_q && ctype == mst_pkg::TYPE_B && !acc_q.peripheral_register && (st_q == S_XRD || st_q == S_XWR))
      |-> acc_q.addr == ptr_q[19:0])
    else $error("type B buffer address not the pointer");
  ism_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (done_valid && done_q.clr_ism) |-> cnt_zero)
    else $error("mode bit cleared with count nonzero");
  flag_rule_a: assert property (@(posedge aclk) disable iff (!aresetn)
    done_valid |-> (done_q.clr_flag == (done_q.clr_ism && suppress)))
    else $error("request flag clear disagrees with suppress");
  end_raise_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && done_valid && done_q.clr_ism && !suppress) |=> end_irq)
    else $error("end interrupt not raised");
  end_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (end_irq && !end_irq_ack) |=> end_irq)
    else $error("end interrupt dropped before acknowledge");
  ring_reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ack_go && st_q == S_RNG && acc_rdata[7:0] == mst_pkg::ONE8)
      |=> rc_q == $past(acc_rdata[15:8]))
    else $error("ring counter not reloaded from modulo");
  mpd_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ack_go && st_q == S_OWR)
      |=> mpd_q == (dir ? $past(mpd_q) - mst_pkg::ONE24 : $past(mpd_q) + mst_pkg::ONE24))
    else $error("data pointer did not step by one");
endmodule

// ===== src/mst_pkg.sv
// Shared constants and carriers for the interrupt-driven transfer engine.
// Assumes byte-addressed memory with a 20-bit space and 8-bit register addresses.
package mst_pkg;
  // ==========================================================
  // Mode byte layout
  localparam int unsigned MODE_TYPE_LSB = 0;
  localparam int unsigned MODE_TYPE_MSB = 1;
  localparam int unsigned MODE_DIR_BIT = 2;
  localparam int unsigned MODE_WIDE_BIT = 3;
  localparam int unsigned MODE_TSTEP_BIT = 4;
  localparam int unsigned MODE_ADD_BIT = 5;
  localparam int unsigned MODE_RING_BIT = 6;
  localparam int unsigned MODE_SUPPRESS_BIT = 7;
  localparam logic [1:0] TYPE_CNT = 2'h0;
  localparam logic [1:0] TYPE_A = 2'h1;
  localparam logic [1:0] TYPE_B = 2'h2;
  localparam logic [1:0] TYPE_C = 2'h3;
  // ==========================================================
  // Channel field offsets below the channel pointer
  localparam logic [7:0] OFF_CNT_W = 8'h01;
  localparam logic [7:0] OFF_PERIPH_REG_PTR_A = 8'h01;
  localparam logic [7:0] OFF_PERIPH_REG_PTR_W = 8'h02;
  localparam logic [7:0] OFF_MP = 8'h05;
  localparam logic [7:0] OFF_DATA_DEST_PTR = 8'h06;
  localparam logic [7:0] OFF_MPD = 8'h09;
  localparam logic [7:0] OFF_RING = 8'h0b;
  localparam logic [7:0] ONE8 = 8'h01;
  localparam logic [23:0] ONE24 = 24'h000001;
  localparam logic [23:0] TWO24 = 24'h000002;
  // Internal RAM window and peripheral register space upper address bits
  localparam logic [11:0] RAM_BASE_LOW = 12'h0fe;
  localparam logic [11:0] RAM_BASE_HIGH = 12'hffe;
  localparam logic [11:0] SFR_BASE = 12'h000;
  // Access sizes, in bytes minus one
  localparam logic [1:0] SIZE_1 = 2'h0;
  localparam logic [1:0] SIZE_2 = 2'h1;
  localparam logic [1:0] SIZE_3 = 2'h2;
  // ==========================================================
  // Register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_XFERS = 8'h08;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_LOC_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_END_BIT = 1;
  localparam int unsigned ST_BAD_BIT = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] chan_ptr;
  } mst_req_t;
  typedef struct packed {
    logic peripheral_register;
    logic we;
    logic [1:0] size;
    logic [19:0] addr;
    logic [23:0] wdata;
  } mst_acc_t;
  typedef struct packed {
    logic clr_ism;
    logic clr_flag;
  } mst_done_t;
endpackage

// ===== test/macro_service_transfer_bench.sv
// Self-checking bench: registers over AXI4-Lite, type A, B, C and counter requests.
// Assumes the memory model answers the access port and holds channel and buffers.
`timescale 1ns/1ps
module macro_service_transfer_bench;
  logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1, req_valid = 1'h0, end_irq_ack = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, req_ready, acc_req, acc_ack;
  logic done_valid, end_irq;
  logic [23:0] acc_rdata;
  mst_pkg::mst_req_t req = '0;
  mst_pkg::mst_acc_t acc;
  mst_pkg::mst_done_t done;
  int fail_count = 0, n_compared = 0, total = 0;
  logic [11:0] win = mst_pkg::RAM_BASE_LOW;
  mst_engine mst_engine_i (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .acc_req(acc_req),
    .acc(acc), .acc_rdata(acc_rdata), .acc_ack(acc_ack), .done_valid(done_valid),
    .done(done), .end_irq(end_irq), .end_irq_ack(end_irq_ack)
  );
  mst_mem_model mst_mem_model_i (
    .aclk(aclk), .aresetn(aresetn), .acc_req(acc_req), .acc(acc),
    .acc_rdata(acc_rdata), .acc_ack(acc_ack)
  );
  initial forever #2 aclk = ~aclk;
  // ==========================================
  // Helpers
  task automatic chk(input string nm, input logic [31:0] e, s);
    n_compared++;
    if (s !== e)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic finish_test;
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  function automatic void pk(int a, logic [7:0] v);
    mst_mem_model_i.mem[a] = v;
  endfunction
  function automatic logic [7:0] pe(int a);
    return mst_mem_model_i.mem.exists(a) ? mst_mem_model_i.mem[a] : 8'hxx;
  endfunction
  function automatic int ra(logic [7:0] o);
    return {win, o};
  endfunction
  function automatic logic [19:0] bufa(logic [7:0] p, c, logic w);
    return {win, p - (w ? {c[6:0], 1'h0} : c) - 8'h01};
  endfunction
  // ==========================================
  // Bus cycles
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(negedge aclk); while (arready !== 1'h1);
    @(posedge aclk);
    arvalid <= 1'h0;
    do @(negedge aclk); while (rvalid !== 1'h1);
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'h0;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do @(negedge aclk); while (awready !== 1'h1 || wready !== 1'h1);
    @(posedge aclk);
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    do @(negedge aclk); while (bvalid !== 1'h1);
    r = bresp;
    @(posedge aclk);
    bready <= 1'h0;
  endtask
  task automatic svc(input logic [7:0] m, p);
    @(posedge aclk);
    req <= '{m, p};
    req_valid <= 1'h1;
    do @(negedge aclk); while (req_ready !== 1'h1);
    @(posedge aclk);
    req_valid <= 1'h0;
    do @(negedge aclk); while (done_valid !== 1'h1);
  endtask
  // One channel served until its count runs out
  task automatic run(input logic [1:0] t, input logic w, d, s, input logic [7:0] c);
    logic [7:0] p;
    logic [19:0] mp, ba, rg;
    logic [15:0] v;
    logic ta;
    ta = (t == mst_pkg::TYPE_A);
    p = ta ? 8'h40 : 8'h80;
    mp = 20'($urandom);
    rg = 20'h00020;
    pk(ra(p), ta ? c : 8'h00);
    pk(ra(p - 8'h01), ta ? 8'h20 : c);
    pk(ra(p - 8'h02), 8'h20);
    for (int i = 0; i < 3; i++)
      pk(ra(p - 8'h05 + 8'(i)), (i == 2) ? {4'h0, mp[19:16]} : mp[8*i+:8]);
    for (int k = c; k > 0; k--)
    begin
      ba = ta ? bufa(p, 8'(k), w) : mp + 20'((c - k) * (w + 1));
      v = 16'($urandom);
      for (int i = 0; i <= w; i++)
        pk((d ? rg : ba) + i, v[8*i+:8]);
      svc({s, 3'h0, w, d, t}, p);
      chk("clr_ism", k == 1, done.clr_ism);
      chk("clr_flag", k == 1 && s, done.clr_flag);
      for (int i = 0; i <= w; i++)
        chk("moved", v[8*i+:8], pe((d ? ba : rg) + i));
      total++;
    end
    tail(ra(ta ? p : p - 8'h01), s);
  endtask
  // Count, end interrupt and its acknowledge once a channel has run out
  task automatic tail(input int ca, input logic s);
    chk("count", 8'h00, pe(ca));
    repeat (2) @(negedge aclk);
    chk("end_irq", !s, end_irq);
    @(posedge aclk);
    end_irq_ack <= 1'h1;
    @(posedge aclk);
    end_irq_ack <= 1'h0;
    @(negedge aclk);
    chk("end_irq ack", 1'h0, end_irq);
  endtask
  // Type C: timer data to compare register 0x30, pattern byte to register 0x40
  task automatic runc(input logic w, d, ts, ad, rg, s, input logic [7:0] c, mr);
    logic [7:0] p, rc, od;
    logic [19:0] tp, dp;
    logic [15:0] cmp, td;
    p = 8'hc0;
    tp = {4'h1, 16'($urandom)};
    dp = {4'h2, 16'($urandom)};
    cmp = 16'($urandom);
    rc = mr;
    pk(ra(p), 8'h00);
    pk(ra(p - 8'h01), c);
    pk(ra(p - 8'h02), 8'h30);
    pk(ra(p - 8'h06), 8'h40);
    pk(ra(p - 8'h0b), rc);
    pk(ra(p - 8'h0a), mr);
    pk(32'h30, cmp[7:0]);
    pk(32'h31, cmp[15:8]);
    for (int i = 0; i < 3; i++)
    begin
      pk(ra(p - 8'h05 + 8'(i)), (i == 2) ? {4'h0, tp[19:16]} : tp[8*i+:8]);
      pk(ra(p - 8'h09 + 8'(i)), (i == 2) ? {4'h0, dp[19:16]} : dp[8*i+:8]);
    end
    for (int k = c; k > 0; k--)
    begin
      td = 16'($urandom);
      od = 8'($urandom);
      pk(tp, td[7:0]);
      pk(tp + 1, td[15:8]);
      pk(dp, od);
      svc({s, rg, ad, ts, w, d, 2'h3}, p);
      cmp = ad ? cmp + td : td;
      if (ts)
        tp = d ? tp - 20'(w + 1) : tp + 20'(w + 1);
      dp = d ? dp - 20'h1 : dp + 20'h1;
      if (rg)
      begin
        rc = rc - 8'h01;
        if (rc == 8'h00)
        begin
          dp = d ? dp + 20'(mr) : dp - 20'(mr);
          rc = mr;
        end
      end
      for (int i = 0; i <= w; i++)
        chk("compare reg", cmp[8*i+:8], pe(32'h30 + i));
      chk("data reg", od, pe(32'h40));
      chk("timer ptr", tp[7:0], pe(ra(p - 8'h05)));
      chk("data ptr", dp[15:0], {pe(ra(p - 8'h08)), pe(ra(p - 8'h09))});
      chk("ring count", rc, pe(ra(p - 8'h0b)));
      chk("clr_ism", k == 1, done.clr_ism);
      chk("clr_flag", k == 1 && s, done.clr_flag);
      total++;
    end
    tail(ra(p - 8'h01), s);
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    logic [1:0] r;
    logic [31:0] x;
    void'($urandom(32'h763f));
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    axr(mst_pkg::REG_CTRL, x, r);
    chk("ctrl reset", 32'h1, x);
    axr(8'h0c, x, r);
    chk("unmapped resp", mst_pkg::RESP_SLVERR, r);
    run(mst_pkg::TYPE_A, 1'h1, 1'h0, 1'h0, 8'h01);
    for (int n = 0; n < 12; n++)
      run(n < 6 ? mst_pkg::TYPE_A : mst_pkg::TYPE_B, n[1], n[2], n[0], 8'($urandom_range(4, 1)));
    for (int n = 0; n < 8; n++)
      runc(n[0], n[1], n[2], n[0] ^ n[1], n[0] | !n[2], n[1] ^ n[2],
           8'($urandom_range(6, 1)), 8'($urandom_range(3, 1)));
    axr(mst_pkg::REG_XFERS, x, r);
    chk("xfers", 32'(total), x);
    svc(8'h00, 8'h40);
    axr(mst_pkg::REG_STATUS, x, r);
    chk("bad mode", 1'h1, x[mst_pkg::ST_BAD_BIT]);
    axw(mst_pkg::REG_STATUS, 32'h4, r);
    axr(mst_pkg::REG_STATUS, x, r);
    chk("bad clear", 1'h0, x[mst_pkg::ST_BAD_BIT]);
    axw(mst_pkg::REG_CTRL, 32'h0, r);
    @(negedge aclk);
    chk("req_ready disabled", 1'h0, req_ready);
    axw(mst_pkg::REG_CTRL, 32'h3, r);
    chk("ctrl resp", mst_pkg::RESP_OKAY, r);
    axr(mst_pkg::REG_CTRL, x, r);
    chk("ctrl write", 32'h3, x);
    win = mst_pkg::RAM_BASE_HIGH;
    run(mst_pkg::TYPE_A, 1'h0, 1'h1, 1'h0, 8'h02);
    axw(8'h0c, 32'h0, r);
    chk("unmapped write resp", mst_pkg::RESP_SLVERR, r);
    @(posedge aclk);
    ce <= 1'h0;
    @(negedge aclk);
    chk("ce low ready", 1'h0, req_ready);
    @(posedge aclk);
    ce <= 1'h1;
    finish_test();
  end
  initial
  begin
    #200000;
    fail_count++;
    $display("ERROR watchdog expected done seen hang");
    finish_test();
  end
endmodule

// ===== test/mst_mem_model.sv
// Memory and peripheral register responder on the engine's access port.
// Assumes one byte store for RAM and registers, little-endian multi-byte access.
`timescale 1ns/1ps
module mst_mem_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Access port
  input wire logic acc_req,
  input wire mst_pkg::mst_acc_t acc,
  output logic [23:0] acc_rdata,
  output logic acc_ack
);
  logic [7:0] mem [int];
  initial acc_ack = 1'h0;
  initial acc_rdata = 24'h000000;
  // ==========================================
  // Random wait exercises slow answers; read data turns over once taken
  always @(posedge aclk)
  begin
    if (!aresetn || acc_ack)
    begin
      acc_ack <= 1'h0;
      acc_rdata <= ~acc_rdata;
    end
    else if (acc_req && $urandom_range(2) == 0)
    begin
      acc_ack <= 1'h1;
      for (int i = 0; i <= int'(acc.size); i++)
      begin
        if (acc.we)
          mem[acc.addr + i] = acc.wdata[8*i+:8];
        else
          acc_rdata[8*i+:8] <= mem.exists(acc.addr + i) ? mem[acc.addr + i] : 8'h00;
      end
    end
  end
endmodule
